/* File: hw/bfs_pkg.sv */
// Constants and types for the buck fault and soft-start sequencer
package bfs_pkg;
  // Clock
  localparam int CLK_PERIOD_NS = 40;
  // Fault filter, least time, rounded up
  localparam int FILTER_NS = 5000;
  localparam int FILTER_CYC = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Minimum off-time, longest time, rounded down, at least one cycle
  localparam int MIN_OFF_NS = 550;
  localparam int MIN_OFF_CYC = (MIN_OFF_NS / CLK_PERIOD_NS) < 1 ? 1 :
                               (MIN_OFF_NS / CLK_PERIOD_NS);
  localparam int MIN_OFF_FACTOR_SS1 = 2;
  // Soft-start in switching cycles
  localparam int SS_STEP_CYC = 110;
  localparam int SS_STEPS = 4;
  localparam int SS_TOTAL_CYC = SS_STEP_CYC * SS_STEPS;
  localparam int SS_CNT_W = 9;
  localparam int FLT_CNT_W = 8;
  localparam int MOFF_CNT_W = 6;
  // Current-limit steps: 25, 50, 75, 100 percent
  localparam logic [1:0] CL_25 = 2'h0;
  localparam logic [1:0] CL_50 = 2'h1;
  localparam logic [1:0] CL_75 = 2'h2;
  localparam logic [1:0] CL_100 = 2'h3;
  // Positions in the synchronised pin vector
  localparam int IX_POR = 0;
  localparam int IX_LOCK = 1;
  localparam int IX_EN = 2;
  localparam int IX_OV = 3;
  localparam int IX_UV = 4;
  localparam int IX_PG = 5;
  localparam int IX_ON = 6;
  localparam int IX_DLOFF = 7;
  localparam int IX_PHLOW = 8;
  localparam int IX_PHHI = 9;
  localparam int PIN_W = 10;
  // Fault filter indices
  localparam int FX_OV = 0;
  localparam int FX_UV = 1;
  // Switching states, one-hot
  typedef enum logic [6:0] {
    BFS_OFF = 7'h01,
    BFS_LOW = 7'h02,
    BFS_WAIT_HI = 7'h04,
    BFS_HIGH = 7'h08,
    BFS_WAIT_LO = 7'h10,
    BFS_OV_LATCH = 7'h20,
    BFS_UV_LATCH = 7'h40
  } bfs_state_t;
endpackage : bfs_pkg

/* File: hw/bfs_sequencer.sv */
// Fault latch, soft-start and gate interlock of one buck channel
`timescale 1ns/1ps
module bfs_sequencer
  import bfs_pkg::*;
#(
  parameter int SS_STEP = SS_STEP_CYC,
  parameter int FILTER = FILTER_CYC
) (
  // Clock, reset, enable
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic I_CE,
  // Analog comparator pins
  input wire logic I_SUPPLY_POR_OK,
  input wire logic I_SUPPLY_LOCKOUT_OK,
  input wire logic I_ENABLE_POWERSAVE_PIN,
  input wire logic I_OV_DETECT,
  input wire logic I_UV_DETECT,
  input wire logic I_PG_DETECT,
  input wire logic I_ON_REQUEST,
  input wire logic I_LOW_GATE_OFF_SENSE,
  input wire logic I_PHASE_NODE_LOW,
  input wire logic I_PHASE_NODE_HIGH,
  // Gate drive
  output logic O_GATE_DRIVE_EN,
  output logic O_HIGH_GATE_DRIVE,
  output logic O_HIGH_GATE_STRONG,
  output logic O_LOW_GATE_DRIVE,
  // Soft-start and bias
  output logic O_BIAS_EN,
  output logic [1:0] O_CURRENT_LIMIT_STEP,
  output logic O_DOUBLE_MIN_OFF,
  output logic O_SENSE_OFFSET_EN,
  output logic O_SOFTSTART_DONE,
  // Status
  output logic O_POWER_GOOD_OUT_O,
  output logic O_POWER_GOOD_OUT_OE,
  output logic O_OV_FAULT,
  output logic O_UV_FAULT
);

  if (SS_STEP < 1 || SS_STEP * SS_STEPS >= (1 << SS_CNT_W)) begin : g_chk_ss
    $error("SS_STEP out of range");
  end
  if (FILTER < 1 || FILTER >= (1 << FLT_CNT_W)) begin : g_chk_flt
    $error("FILTER out of range");
  end

  localparam logic [SS_CNT_W-1:0] SS_S1 = SS_CNT_W'(SS_STEP);
  localparam logic [SS_CNT_W-1:0] SS_S2 = SS_CNT_W'(2 * SS_STEP);
  localparam logic [SS_CNT_W-1:0] SS_S3 = SS_CNT_W'(3 * SS_STEP);
  localparam logic [SS_CNT_W-1:0] SS_END = SS_CNT_W'(SS_STEPS * SS_STEP);
  localparam logic [FLT_CNT_W-1:0] FLT_LAST = FLT_CNT_W'(FILTER - 1);
  localparam logic [MOFF_CNT_W-1:0] MOFF_N = MOFF_CNT_W'(MIN_OFF_CYC);
  localparam logic [MOFF_CNT_W-1:0] MOFF_D =
    MOFF_CNT_W'(MIN_OFF_FACTOR_SS1 * MIN_OFF_CYC);

  // Pin synchroniser
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] sync1_reg;
  logic [PIN_W-1:0] sync2_reg;
  assign pins = {I_PHASE_NODE_HIGH, I_PHASE_NODE_LOW, I_LOW_GATE_OFF_SENSE,
                 I_ON_REQUEST, I_PG_DETECT, I_UV_DETECT, I_OV_DETECT,
                 I_ENABLE_POWERSAVE_PIN, I_SUPPLY_LOCKOUT_OK,
                 I_SUPPLY_POR_OK};

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (I_CE) begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end

  // Core state
  bfs_state_t state_reg, state_next;
  logic [SS_CNT_W-1:0] ss_cnt_reg, ss_cnt_next;
  logic [MOFF_CNT_W-1:0] moff_cnt_reg, moff_cnt_next;
  logic [FLT_CNT_W-1:0] flt_cnt_reg [2];
  logic [FLT_CNT_W-1:0] flt_cnt_next [2];
  logic [1:0] det;
  logic [1:0] trip;
  logic run;
  logic active;
  logic ss_done;
  logic [MOFF_CNT_W-1:0] moff_lim;

  assign run = sync2_reg[IX_POR] & sync2_reg[IX_LOCK] & sync2_reg[IX_EN];
  assign ss_done = (ss_cnt_reg == SS_END);
  assign active = run & (state_reg != BFS_OFF) &
                  (state_reg != BFS_OV_LATCH) & (state_reg != BFS_UV_LATCH);
  assign det[FX_OV] = active & sync2_reg[IX_OV];
  assign det[FX_UV] = active & ss_done & sync2_reg[IX_UV];
  assign moff_lim = (ss_cnt_reg < SS_S1) ? MOFF_D : MOFF_N;

  for (genvar g = 0; g < 2; g++) begin : g_flt
    assign trip[g] = det[g] & (flt_cnt_reg[g] == FLT_LAST);
    always_comb begin
      flt_cnt_next[g] = '0;
      if (det[g] && !trip[g]) begin
        flt_cnt_next[g] = flt_cnt_reg[g] + FLT_CNT_W'(1);
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    ss_cnt_next = ss_cnt_reg;
    moff_cnt_next = moff_cnt_reg;
    if (moff_cnt_reg != '1) begin
      moff_cnt_next = moff_cnt_reg + MOFF_CNT_W'(1);
    end
    if (!run) begin
      state_next = BFS_OFF;
      ss_cnt_next = '0;
    end else if (trip[FX_OV]) begin
      state_next = BFS_OV_LATCH;
    end else if (trip[FX_UV]) begin
      state_next = BFS_UV_LATCH;
    end else begin
      case (state_reg)
        BFS_OFF: begin
          if (sync2_reg[IX_PHLOW]) begin
            state_next = BFS_LOW;
            moff_cnt_next = '0;
          end
        end
        BFS_LOW: begin
          if (moff_cnt_reg >= moff_lim - MOFF_CNT_W'(1) &&
              sync2_reg[IX_ON]) begin
            state_next = BFS_WAIT_HI;
          end
        end
        BFS_WAIT_HI: begin
          if (sync2_reg[IX_DLOFF]) begin
            state_next = BFS_HIGH;
          end
        end
        BFS_HIGH: begin
          if (!sync2_reg[IX_ON]) begin
            state_next = BFS_WAIT_LO;
          end
        end
        BFS_WAIT_LO: begin
          if (sync2_reg[IX_PHLOW]) begin
            state_next = BFS_LOW;
            moff_cnt_next = '0;
            if (!ss_done) begin
              ss_cnt_next = ss_cnt_reg + SS_CNT_W'(1);
            end
          end
        end
        BFS_OV_LATCH: state_next = BFS_OV_LATCH;
        BFS_UV_LATCH: state_next = BFS_UV_LATCH;
        default: state_next = BFS_OFF;
      endcase
    end
  end

  // Registered outputs, decoded from next state and synchronised pins
  logic gate_en_next, high_next, strong_next, low_next;
  logic [1:0] cl_next;
  logic dbl_next, ofs_next, ssd_next, pg_oe_next, ov_next, uv_next;

  always_comb begin
    gate_en_next = (state_next != BFS_OFF) && (state_next != BFS_UV_LATCH);
    high_next = (state_next == BFS_HIGH);
    strong_next = high_next && sync2_reg[IX_PHHI];
    // low drive held on in overvoltage
    low_next = (state_next == BFS_LOW) || (state_next == BFS_OV_LATCH);
    if (ss_cnt_next < SS_S1) begin
      cl_next = CL_25;
    end else if (ss_cnt_next < SS_S2) begin
      cl_next = CL_50;
    end else if (ss_cnt_next < SS_S3) begin
      cl_next = CL_75;
    end else begin
      cl_next = CL_100;
    end
    dbl_next = (ss_cnt_next < SS_S1);
    ofs_next = dbl_next && (state_next != BFS_OFF);
    ssd_next = (ss_cnt_next == SS_END);
    pg_oe_next = !(ssd_next && sync2_reg[IX_PG] &&
                   (state_next != BFS_OFF) &&
                   (state_next != BFS_OV_LATCH) &&
                   (state_next != BFS_UV_LATCH));
    ov_next = (state_next == BFS_OV_LATCH);
    uv_next = (state_next == BFS_UV_LATCH);
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_reg <= BFS_OFF;
      ss_cnt_reg <= '0;
      moff_cnt_reg <= '0;
      flt_cnt_reg[0] <= '0;
      flt_cnt_reg[1] <= '0;
      O_GATE_DRIVE_EN <= 1'b0;
      O_HIGH_GATE_DRIVE <= 1'b0;
      O_HIGH_GATE_STRONG <= 1'b0;
      O_LOW_GATE_DRIVE <= 1'b0;
      O_BIAS_EN <= 1'b0;
      O_CURRENT_LIMIT_STEP <= CL_25;
      O_DOUBLE_MIN_OFF <= 1'b1;
      O_SENSE_OFFSET_EN <= 1'b0;
      O_SOFTSTART_DONE <= 1'b0;
      O_POWER_GOOD_OUT_O <= 1'b0;
      O_POWER_GOOD_OUT_OE <= 1'b1;
      O_OV_FAULT <= 1'b0;
      O_UV_FAULT <= 1'b0;
    end else if (I_CE) begin
      state_reg <= state_next;
      ss_cnt_reg <= ss_cnt_next;
      moff_cnt_reg <= moff_cnt_next;
      flt_cnt_reg[0] <= flt_cnt_next[0];
      flt_cnt_reg[1] <= flt_cnt_next[1];
      O_GATE_DRIVE_EN <= gate_en_next;
      O_HIGH_GATE_DRIVE <= high_next;
      O_HIGH_GATE_STRONG <= strong_next;
      O_LOW_GATE_DRIVE <= low_next;
      O_BIAS_EN <= sync2_reg[IX_POR];
      O_CURRENT_LIMIT_STEP <= cl_next;
      O_DOUBLE_MIN_OFF <= dbl_next;
      O_SENSE_OFFSET_EN <= ofs_next;
      O_SOFTSTART_DONE <= ssd_next;
      O_POWER_GOOD_OUT_O <= 1'b0;
      O_POWER_GOOD_OUT_OE <= pg_oe_next;
      O_OV_FAULT <= ov_next;
      O_UV_FAULT <= uv_next;
    end
  end

  // Checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN || !I_CE);

  property p_ov_drive;
    state_reg == BFS_OV_LATCH |-> O_LOW_GATE_DRIVE && !O_HIGH_GATE_DRIVE
      && O_OV_FAULT;
  endproperty
  a_ov_drive: assert property (p_ov_drive)
    else $error("overvoltage latch drive wrong");
  property p_ov_filter;
    (state_reg != BFS_OV_LATCH) ##1 (state_reg == BFS_OV_LATCH) |->
      $past(flt_cnt_reg[0]) == FLT_LAST;
  endproperty
  a_ov_filter: assert property (p_ov_filter)
    else $error("overvoltage latched before filter delay");
  property p_uv_drive;
    state_reg == BFS_UV_LATCH |-> !O_GATE_DRIVE_EN && !O_HIGH_GATE_DRIVE
      && !O_LOW_GATE_DRIVE;
  endproperty
  a_uv_drive: assert property (p_uv_drive)
    else $error("undervoltage latch not tri-stated");
  property p_uv_filter;
    (state_reg != BFS_UV_LATCH) ##1 (state_reg == BFS_UV_LATCH) |->
      $past(flt_cnt_reg[1]) == FLT_LAST && $past(ss_done);
  endproperty
  a_uv_filter: assert property (p_uv_filter)
    else $error("undervoltage latched early");
  property p_lockout;
    !sync2_reg[IX_LOCK] |=> state_reg == BFS_OFF && ss_cnt_reg == '0
      && !O_GATE_DRIVE_EN;
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("lockout did not shut down");
  property p_dead_hi;
    $rose(O_HIGH_GATE_DRIVE) |-> $past(sync2_reg[IX_DLOFF])
      && !$past(O_LOW_GATE_DRIVE);
  endproperty
  a_dead_hi: assert property (p_dead_hi)
    else $error("high drive before low drive off");
  property p_dead_lo;
    $rose(O_LOW_GATE_DRIVE) && state_reg == BFS_LOW |->
      $past(sync2_reg[IX_PHLOW]) && !$past(O_HIGH_GATE_DRIVE);
  endproperty
  a_dead_lo: assert property (p_dead_lo)
    else $error("low drive before phase low");
  property p_pgood;
    !O_POWER_GOOD_OUT_OE |-> ss_cnt_reg == SS_END && O_SOFTSTART_DONE;
  endproperty
  a_pgood: assert property (p_pgood)
    else $error("power good released during soft-start");
  property p_step;
    ss_cnt_reg < SS_S1 |-> O_CURRENT_LIMIT_STEP == CL_25
      && O_DOUBLE_MIN_OFF;
  endproperty
  a_step: assert property (p_step)
    else $error("first soft-start step wrong");

  c_ov: cover property (state_reg == BFS_OV_LATCH);
  c_uv: cover property (state_reg == BFS_UV_LATCH);
  c_ss: cover property ($rose(O_SOFTSTART_DONE));
  c_pg: cover property ($fell(O_POWER_GOOD_OUT_OE));

endmodule : bfs_sequencer

/* File: tb/bfs_power_stage.sv */
// Behavioural power stage answering the gate drives with sensed levels
`timescale 1ns/1ps
module bfs_power_stage (
  // Clock and answer speed
  input wire logic i_clk,
  input wire logic i_slow,
  // Gate drives from the sequencer
  input wire logic i_drive_en,
  input wire logic i_high_drive,
  input wire logic i_low_drive,
  // Sensed levels back to the sequencer
  output logic o_low_off,
  output logic o_phase_low,
  output logic o_phase_high
);
  logic [2:0] lo_q = 3'h0;
  logic [2:0] hi_q = 3'h0;
  logic lo_on;
  logic hi_on;
  // Gate charge lingers one cycle, three when slow
  always_ff @(posedge i_clk) begin
    lo_q <= {lo_q[1:0], i_drive_en & i_low_drive};
    hi_q <= {hi_q[1:0], i_drive_en & i_high_drive};
  end
  assign lo_on = lo_q[0] | (i_slow & |lo_q);
  assign hi_on = hi_q[0] | (i_slow & |hi_q);
  assign o_low_off = ~(lo_on | (i_drive_en & i_low_drive));
  assign o_phase_low = ~(hi_on | (i_drive_en & i_high_drive));
  // Node passes the strong-stage level only after the rise delay
  assign o_phase_high = i_drive_en & i_high_drive &
                        (i_slow ? &hi_q : hi_q[0]);
endmodule : bfs_power_stage

/* File: tb/tb_top.sv */
// Self-checking bench for the buck fault and soft-start sequencer
`timescale 1ns/1ps
module tb_top;
  import bfs_pkg::*;
  localparam int SSN = 3;
  localparam int FLT = 4;
  logic clk = 0;
  logic rst_n = 0;
  logic por = 0, lock = 0, en = 0, ov = 0, uv = 0, pg = 0, on_req = 0;
  logic slow = 0;
  logic drv_en, dh, dh_st, dl, bias, dbl, offs, done, pg_o, pg_oe, ovf, uvf;
  logic lo_off, ph_lo, ph_hi;
  logic [1:0] cl;
  logic [8:0] obs;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;

  always #20 clk = ~clk;
  assign obs = {bias, pg_oe, uvf, ovf, done, dl, dh_st, dh, drv_en};

  bfs_sequencer #(.SS_STEP(SSN), .FILTER(FLT)) dut (
    .I_CLK(clk), .I_RESETN(rst_n), .I_CE(1'b1),
    .I_SUPPLY_POR_OK(por), .I_SUPPLY_LOCKOUT_OK(lock),
    .I_ENABLE_POWERSAVE_PIN(en), .I_OV_DETECT(ov), .I_UV_DETECT(uv),
    .I_PG_DETECT(pg), .I_ON_REQUEST(on_req),
    .I_LOW_GATE_OFF_SENSE(lo_off), .I_PHASE_NODE_LOW(ph_lo),
    .I_PHASE_NODE_HIGH(ph_hi), .O_GATE_DRIVE_EN(drv_en),
    .O_HIGH_GATE_DRIVE(dh), .O_HIGH_GATE_STRONG(dh_st),
    .O_LOW_GATE_DRIVE(dl), .O_BIAS_EN(bias), .O_CURRENT_LIMIT_STEP(cl),
    .O_DOUBLE_MIN_OFF(dbl), .O_SENSE_OFFSET_EN(offs),
    .O_SOFTSTART_DONE(done), .O_POWER_GOOD_OUT_O(pg_o),
    .O_POWER_GOOD_OUT_OE(pg_oe), .O_OV_FAULT(ovf), .O_UV_FAULT(uvf));

  bfs_power_stage stage (
    .i_clk(clk), .i_slow(slow), .i_drive_en(drv_en), .i_high_drive(dh),
    .i_low_drive(dl), .o_low_off(lo_off), .o_phase_low(ph_lo),
    .o_phase_high(ph_hi));

  task automatic chk(input string nm, input logic [9:0] seen,
                     input logic [9:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Bounded wait for one observed output to reach a level
  task automatic wt(input int b, input logic v, input string nm);
    int n;
    n = 0;
    while (obs[b] !== v && n < 300) begin
      tick(1);
      n++;
    end
    chk(nm, obs[b], v);
  endtask : wt

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  // Drive overlap and strong stage without high drive are never allowed
  always @(negedge clk) begin
    chk("overlap", {dh & dl, dh_st & ~dh}, 2'h0);
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  // One switching cycle, entered while the low drive is on
  task automatic sw(input int c);
    int len;
    len = 0;
    while (dl === 1'b1 && len < 100) begin
      tick(1);
      len++;
    end
    if (c == 1) chk("min_off_first", len >= 2 * MIN_OFF_CYC, 1);
    if (c == 4 * SSN) chk("min_off", len <= MIN_OFF_CYC + 1, 1);
    wt(1, 1, "high_drive");
    wt(2, 1, "strong_stage");
    chk("cl_step", cl, (c - 1) / SSN);
    chk("dbl_off", dbl, c <= SSN);
    chk("ss_done", done, 0);
    chk("pg_held", pg_oe, 1);
    chk("uv_masked", uvf, 0);
    @(posedge clk) on_req <= 0;
    wt(3, 1, "low_drive");
    @(posedge clk) on_req <= 1;
  endtask : sw

  task automatic t_start();
    @(posedge clk) por <= 1;
    tick(3);
    chk("bias", bias, 1);
    chk("locked_out", drv_en, 0);
    @(posedge clk) {lock, en, pg, on_req, uv} <= 5'h1f;
    tick(3);
    chk("drive_en", drv_en, 1);
    chk("low_first", {dh, dl}, 2'h1);
    chk("offset", offs, 1);
    $display("test start finished");
  endtask : t_start

  task automatic t_ss();
    wt(3, 1, "low_first");
    for (int c = 1; c <= 4 * SSN; c++) begin
      sw(c);
      if (c == 2) @(posedge clk) uv <= 0;
    end
    wt(7, 0, "pg_release");
    chk("offset_end", offs, 0);
    chk("ss_done_end", done, 1);
    chk("pg_data", pg_o, 0);
    $display("test soft-start finished");
  endtask : t_ss

  task automatic t_ov();
    @(posedge clk) ov <= 1;
    repeat (FLT - 1) @(posedge clk);
    ov <= 0;
    tick(8);
    chk("ov_glitch", ovf, 0);
    @(posedge clk) ov <= 1;
    wt(5, 1, "ov_fault");
    chk("ov_drive", {drv_en, dh, dl}, 3'h5);
    @(posedge clk) {ov, uv} <= 2'h1;
    tick(12);
    chk("ov_held", {ovf, uvf, dl}, 3'h5);
    @(posedge clk) en <= 0;
    tick(3);
    chk("en_low", drv_en, 0);
    chk("ov_clear", ovf, 0);
    @(posedge clk) {en, uv, slow} <= 3'h7;
    tick(3);
    chk("restart", {drv_en, dl, cl, done}, 5'h18);
    $display("test overvoltage finished");
  endtask : t_ov

  task automatic t_uv();
    @(posedge clk) uv <= 1;
    wt(6, 1, "uv_fault");
    chk("uv_tristate", {drv_en, ovf}, 2'h0);
    @(posedge clk) lock <= 0;
    tick(3);
    chk("lockout", drv_en, 0);
    chk("uv_clear", uvf, 0);
    @(posedge clk) {lock, uv} <= 2'h2;
    tick(3);
    chk("relock", {drv_en, dl, done}, 3'h6);
    @(posedge clk) por <= 0;
    tick(3);
    chk("por_drop", {bias, drv_en}, 2'h0);
    $display("test undervoltage finished");
  endtask : t_uv

  initial begin
    repeat (6) @(posedge clk);
    chk("reset_values", {drv_en, dh, dl, bias, cl, dbl, pg_oe, ovf, uvf},
        10'h00c);
    rst_n <= 1;
    t_start();
    t_ss();
    t_ov();
    t_ss();
    t_uv();
    final_report();
  end
endmodule : tb_top
